// ==== inc/pfta_pkg.sv ====
// Shared constants and types for program flash table access
package pfta_pkg;
  localparam int PTR_W = 22;
  localparam int PC_W = 21;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int FLASH_BYTES = 65536;
  localparam int FLASH_AW = 16;
  localparam int BLOCK_BYTES = 64;
  localparam int BLOCK_AW = 6;
  localparam int CFG_SPACE_BIT = 21;
  localparam int JUMP_W = 20;
  localparam int BRANCH_W = 11;
  localparam int CNT_W = 32;
  localparam logic [7:0] HOLD_PRESET = 8'hff;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam logic [7:0] CFG_READ_VALUE = 8'hff;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [20:0] PC_RESET = 21'h000000;
  localparam logic [21:0] PTR_RESET = 22'h000000;

  // Control register bit positions
  localparam int CTL_PGD = 7;
  localparam int CTL_CONFIG_SPACE_SELECT = 6;
  localparam int CTL_FREE = 4;
  localparam int CTL_ERR = 3;
  localparam int CTL_WRITE_ENABLE_BIT = 2;
  localparam int CTL_WR = 1;

  // Long write duration
  localparam int WRITE_TIME_US = 2000;
  localparam int CLK_MHZ = 25;
  localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;

  typedef enum logic [2:0] {
    OP_TBL_RD, OP_TBL_WT, OP_SET_PTR, OP_WR_CTRL,
    OP_WR_KEY, OP_PC_STEP, OP_PC_JUMP, OP_PC_BRANCH
  } pfta_op_t;

  // Host register map, byte addresses
  localparam int AVS_AW = 5;
  localparam logic [4:0] REG_CMD = 5'h00;
  localparam logic [4:0] REG_DATA = 5'h04;
  localparam logic [4:0] REG_PTR = 5'h08;
  localparam logic [4:0] REG_STATUS = 5'h0c;
  localparam logic [4:0] REG_PC = 5'h10;

  // Command register fields and codes
  localparam int CMD_INC_BIT = 4;
  localparam logic [2:0] CMD_TBL_RD = 3'h0;
  localparam logic [2:0] CMD_TBL_WT = 3'h1;
  localparam logic [2:0] CMD_SET_PTR = 3'h2;
  localparam logic [2:0] CMD_PROGRAM = 3'h3;
  localparam logic [2:0] CMD_ERASE = 3'h4;
  localparam logic [2:0] CMD_PC_STEP = 3'h5;
  localparam logic [2:0] CMD_PC_JUMP = 3'h6;
  localparam logic [2:0] CMD_PC_BRANCH = 3'h7;

  // Status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_STALL = 1;
  localparam int ST_GIE = 2;
  localparam int ST_CTL_LSB = 8;

  // Host sequence steps
  localparam logic [2:0] STEP_CTRL = 3'h0;
  localparam logic [2:0] STEP_KEY1 = 3'h1;
  localparam logic [2:0] STEP_KEY2 = 3'h2;
  localparam logic [2:0] STEP_START = 3'h3;
  localparam logic [2:0] STEP_GAP = 3'h4;
endpackage

// ==== inc/pfta_if.sv ====
// Link between processor core and program flash table access logic
`timescale 1ns/1ps
interface pfta_if;
  logic req;
  pfta_pkg::pfta_op_t op;
  logic [pfta_pkg::BYTE_W-1:0] wdata;
  logic [pfta_pkg::PTR_W-1:0] addr;
  logic post_inc;
  logic stall;
  logic [pfta_pkg::BYTE_W-1:0] latch;
  logic [pfta_pkg::PTR_W-1:0] ptr;
  logic [pfta_pkg::BYTE_W-1:0] ctrl;
  logic [pfta_pkg::PC_W-1:0] pc;

  modport dev (
    input req, op, wdata, addr, post_inc,
    output stall, latch, ptr, ctrl, pc
  );
  modport core (
    output req, op, wdata, addr, post_inc,
    input stall, latch, ptr, ctrl, pc
  );
endinterface

// ==== logic/pfta_flash_dev.sv ====
// Device end: table pointer, latch, holding bank, long write, counter
`timescale 1ns/1ps

module pfta_flash_dev #(
  parameter int WRITE_CYCLES = pfta_pkg::WRITE_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic warm_reset,
  pfta_if.dev bus,
  output logic [pfta_pkg::WORD_W-1:0] fetch_word
);

  typedef enum logic [0:0] {DS_IDLE, DS_LONG} pfta_dstate_t;
  typedef enum logic [1:0] {UK_NONE, UK_FIRST, UK_ARMED} pfta_key_t;

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [pfta_pkg::BYTE_W-1:0] flash_mem [pfta_pkg::FLASH_BYTES];
  logic [pfta_pkg::BYTE_W-1:0] hold_r [pfta_pkg::BLOCK_BYTES];

  pfta_dstate_t state_r;
  pfta_key_t key_r;
  logic [pfta_pkg::CNT_W-1:0] cnt_r;
  logic [pfta_pkg::PTR_W-1:0] ptr_r;
  logic [pfta_pkg::BYTE_W-1:0] latch_r;
  logic [pfta_pkg::PC_W-1:0] pc_r;
  logic [pfta_pkg::PC_W-1:0] pc_nxt;
  logic [pfta_pkg::WORD_W-1:0] fetch_r;
  logic stall_r;
  logic pgd_r;
  logic config_space_select_r;
  logic free_r;
  logic err_r;
  logic write_enable_bit_r;
  logic wr_r;
  logic [pfta_pkg::BYTE_W-1:0] ctl_word;

  // Word view of flash at an even byte address
  function automatic logic [pfta_pkg::WORD_W-1:0] read_word(
    input logic [pfta_pkg::FLASH_AW-1:0] byte_addr
  );
    logic [pfta_pkg::FLASH_AW-1:0] even;
    even = {byte_addr[pfta_pkg::FLASH_AW-1:1], 1'b0};
    return {flash_mem[even | pfta_pkg::FLASH_AW'(1)], flash_mem[even]};
  endfunction

  // Next sequential address plus a signed count of words
  function automatic logic [pfta_pkg::PC_W-1:0] pc_add(
    input logic [pfta_pkg::PC_W-1:0] base,
    input logic [pfta_pkg::PC_W-2:0] words
  );
    return base + pfta_pkg::PC_STEP + {words, 1'b0};
  endfunction

  // ****************************************************************
  // Decode
  // ****************************************************************
  wire idle = state_r == DS_IDLE;
  wire take = bus.req && idle;
  wire op_rd = take && bus.op == pfta_pkg::OP_TBL_RD;
  wire op_wt = take && bus.op == pfta_pkg::OP_TBL_WT;
  wire op_ptr = take && bus.op == pfta_pkg::OP_SET_PTR;
  wire op_ctl = take && bus.op == pfta_pkg::OP_WR_CTRL;
  wire op_key = take && bus.op == pfta_pkg::OP_WR_KEY;
  wire cfg_sel = ptr_r[pfta_pkg::CFG_SPACE_BIT];
  wire [pfta_pkg::FLASH_AW-1:0] flash_addr = ptr_r[pfta_pkg::FLASH_AW-1:0];
  // A process, so the read follows flash updates as well as the address
  logic [pfta_pkg::WORD_W-1:0] rd_word;
  always_comb begin
    rd_word = read_word(flash_addr);
  end
  wire [pfta_pkg::BYTE_W-1:0] rd_half = ptr_r[0] ?
    rd_word[pfta_pkg::WORD_W-1:pfta_pkg::BYTE_W] :
    rd_word[pfta_pkg::BYTE_W-1:0];
  wire [pfta_pkg::BYTE_W-1:0] rd_byte = cfg_sel ?
    pfta_pkg::CFG_READ_VALUE : rd_half;
  wire [pfta_pkg::PTR_W-1:0] ptr_inc = ptr_r + pfta_pkg::PTR_W'(1);
  wire bump = (op_rd || op_wt) && bus.post_inc;
  wire start_req = op_ctl && bus.wdata[pfta_pkg::CTL_WR];
  wire start_ok = start_req && key_r == UK_ARMED && write_enable_bit_r &&
    pgd_r && !config_space_select_r;
  wire done = !idle && cnt_r == pfta_pkg::CNT_W'(WRITE_CYCLES - 1);
  wire [pfta_pkg::FLASH_AW-1:0] block_base =
    {flash_addr[pfta_pkg::FLASH_AW-1:pfta_pkg::BLOCK_AW],
     pfta_pkg::BLOCK_AW'(0)};
  wire [pfta_pkg::PC_W-2:0] branch_words =
    (pfta_pkg::PC_W-1)'(signed'(bus.addr[pfta_pkg::BRANCH_W-1:0]));
  wire [pfta_pkg::PC_W-1:0] jump_target =
    {bus.addr[pfta_pkg::JUMP_W-1:0], 1'b0};

  always_comb begin
    pc_nxt = pc_r;
    if (take) begin
      case (bus.op)
        pfta_pkg::OP_PC_STEP: pc_nxt = pc_add(pc_r, '0);
        pfta_pkg::OP_PC_JUMP: pc_nxt = jump_target;
        pfta_pkg::OP_PC_BRANCH: pc_nxt = pc_add(pc_r, branch_words);
        default: pc_nxt = pc_r;
      endcase
    end
  end

  always_comb begin
    ctl_word = '0;
    ctl_word[pfta_pkg::CTL_PGD] = pgd_r;
    ctl_word[pfta_pkg::CTL_CONFIG_SPACE_SELECT] = config_space_select_r;
    ctl_word[pfta_pkg::CTL_FREE] = free_r;
    ctl_word[pfta_pkg::CTL_ERR] = err_r;
    ctl_word[pfta_pkg::CTL_WRITE_ENABLE_BIT] = write_enable_bit_r;
    ctl_word[pfta_pkg::CTL_WR] = wr_r;
  end

  // ****************************************************************
  // Long write sequencer
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= DS_IDLE;
      cnt_r <= '0;
      stall_r <= 1'b0;
    end else if (warm_reset) begin
      state_r <= DS_IDLE;
      cnt_r <= '0;
      stall_r <= 1'b0;
    end else if (start_ok) begin
      state_r <= DS_LONG;
      cnt_r <= '0;
      stall_r <= 1'b1;
    end else if (done) begin
      state_r <= DS_IDLE;
      stall_r <= 1'b0;
    end else if (!idle) begin
      cnt_r <= cnt_r + pfta_pkg::CNT_W'(1);
    end
  end

  // Unlock keys must arrive as the last two accesses before start
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      key_r <= UK_NONE;
    end else if (warm_reset) begin
      key_r <= UK_NONE;
    end else if (op_key && bus.wdata == pfta_pkg::KEY_FIRST) begin
      key_r <= UK_FIRST;
    end else if (op_key && bus.wdata == pfta_pkg::KEY_SECOND &&
                 key_r == UK_FIRST) begin
      key_r <= UK_ARMED;
    end else if (take) begin
      key_r <= UK_NONE;
    end
  end

  // ****************************************************************
  // Control bits
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pgd_r <= 1'b0;
      config_space_select_r <= 1'b0;
      free_r <= 1'b0;
      write_enable_bit_r <= 1'b0;
      wr_r <= 1'b0;
    end else if (warm_reset) begin
      pgd_r <= 1'b0;
      config_space_select_r <= 1'b0;
      free_r <= 1'b0;
      write_enable_bit_r <= 1'b0;
      wr_r <= 1'b0;
    end else if (op_ctl) begin
      pgd_r <= bus.wdata[pfta_pkg::CTL_PGD];
      config_space_select_r <= bus.wdata[pfta_pkg::CTL_CONFIG_SPACE_SELECT];
      free_r <= bus.wdata[pfta_pkg::CTL_FREE];
      write_enable_bit_r <= bus.wdata[pfta_pkg::CTL_WRITE_ENABLE_BIT];
      wr_r <= start_ok;
    end else if (done) begin
      wr_r <= 1'b0;
    end
  end

  // Error flag: warm reset during a write sets it, writing zero clears it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      err_r <= 1'b0;
    end else if (warm_reset && !idle) begin
      err_r <= 1'b1;
    end else if (op_ctl && !bus.wdata[pfta_pkg::CTL_ERR]) begin
      err_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Table pointer, latch, program counter
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_r <= pfta_pkg::PTR_RESET;
      latch_r <= '0;
    end else if (op_ptr) begin
      ptr_r <= bus.addr;
    end else begin
      if (bump) ptr_r <= ptr_inc;
      if (op_rd) latch_r <= rd_byte;
      if (op_wt) latch_r <= bus.wdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_r <= pfta_pkg::PC_RESET;
      fetch_r <= '0;
    end else if (warm_reset) begin
      pc_r <= pfta_pkg::PC_RESET;
      fetch_r <= '0;
    end else begin
      pc_r <= {pc_nxt[pfta_pkg::PC_W-1:1], 1'b0};
      fetch_r <= read_word(pc_r[pfta_pkg::FLASH_AW-1:0]);
    end
  end

  // ****************************************************************
  // Holding bank and flash array
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < pfta_pkg::BLOCK_BYTES; i++) begin
        hold_r[i] <= pfta_pkg::HOLD_PRESET;
      end
    end else if (warm_reset || done) begin
      for (int i = 0; i < pfta_pkg::BLOCK_BYTES; i++) begin
        hold_r[i] <= pfta_pkg::HOLD_PRESET;
      end
    end else if (op_wt && !cfg_sel) begin
      hold_r[ptr_r[pfta_pkg::BLOCK_AW-1:0]] <= bus.wdata;
    end
  end

  // Programming can only clear bits; erase sets the block to ones
  always_ff @(posedge clk) begin
    if (done && !warm_reset) begin
      for (int i = 0; i < pfta_pkg::BLOCK_BYTES; i++) begin
        if (free_r) begin
          flash_mem[block_base + pfta_pkg::FLASH_AW'(i)] <=
            pfta_pkg::ERASED_BYTE;
        end else begin
          flash_mem[block_base + pfta_pkg::FLASH_AW'(i)] <=
            flash_mem[block_base + pfta_pkg::FLASH_AW'(i)] &
            hold_r[i];
        end
      end
    end
  end

  assign bus.stall = stall_r;
  assign bus.latch = latch_r;
  assign bus.ptr = ptr_r;
  assign bus.pc = pc_r;
  assign fetch_word = fetch_r;

  logic [pfta_pkg::BYTE_W-1:0] ctl_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_r <= '0;
    end else begin
      ctl_r <= ctl_word;
    end
  end
  assign bus.ctrl = ctl_r;

endmodule

// ==== logic/pfta_core_host.sv ====
// Core end: Avalon-MM command registers driving table and write sequences
`timescale 1ns/1ps
module pfta_core_host (
  input wire logic clk,
  input wire logic reset_n,
  pfta_if.core bus,
  input wire logic [pfta_pkg::AVS_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  typedef enum logic [1:0] {HS_IDLE, HS_SEQ, HS_STALL, HS_TAIL}
    pfta_hstate_t;

  pfta_hstate_t state_r;
  logic [2:0] step_r;
  logic erase_r;
  logic gie_r;
  logic wait_r;
  logic [31:0] rdata_r;
  logic [pfta_pkg::BYTE_W-1:0] data_r;
  logic [pfta_pkg::PTR_W-1:0] preg_r;
  logic req_r;
  pfta_pkg::pfta_op_t op_r;
  logic [pfta_pkg::BYTE_W-1:0] wdata_r;
  logic [pfta_pkg::PTR_W-1:0] addr_r;
  logic inc_r;

  logic req_nxt;
  pfta_pkg::pfta_op_t op_nxt;
  logic [pfta_pkg::BYTE_W-1:0] wdata_nxt;
  logic [pfta_pkg::BYTE_W-1:0] ctl_base;
  logic [31:0] rd_mux;

  // ****************************************************************
  // Register slave
  // ****************************************************************
  wire busy = state_r != HS_IDLE;
  wire cmd_hit = avs_write && avs_address == pfta_pkg::REG_CMD;
  wire accept = (avs_read || avs_write) && wait_r && !(cmd_hit && busy);
  wire cmd_go = accept && cmd_hit;
  wire [2:0] cmd_code = avs_writedata[2:0];
  wire long_cmd = cmd_code == pfta_pkg::CMD_PROGRAM ||
    cmd_code == pfta_pkg::CMD_ERASE;

  always_comb begin
    rd_mux = '0;
    case (avs_address)
      pfta_pkg::REG_DATA: rd_mux[pfta_pkg::BYTE_W-1:0] = bus.latch;
      pfta_pkg::REG_PTR: rd_mux[pfta_pkg::PTR_W-1:0] = bus.ptr;
      pfta_pkg::REG_PC: rd_mux[pfta_pkg::PC_W-1:0] = bus.pc;
      pfta_pkg::REG_STATUS: begin
        rd_mux[pfta_pkg::ST_BUSY] = busy;
        rd_mux[pfta_pkg::ST_STALL] = bus.stall;
        rd_mux[pfta_pkg::ST_GIE] = gie_r;
        rd_mux[pfta_pkg::ST_CTL_LSB +: pfta_pkg::BYTE_W] = bus.ctrl;
      end
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_r <= 1'b1;
      rdata_r <= '0;
    end else if (accept) begin
      wait_r <= 1'b0;
      rdata_r <= avs_read ? rd_mux : '0;
    end else begin
      wait_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_r <= '0;
      preg_r <= '0;
    end else if (accept && avs_write) begin
      if (avs_address == pfta_pkg::REG_DATA) begin
        data_r <= avs_writedata[pfta_pkg::BYTE_W-1:0];
      end
      if (avs_address == pfta_pkg::REG_PTR) begin
        preg_r <= avs_writedata[pfta_pkg::PTR_W-1:0];
      end
    end
  end

  // ****************************************************************
  // Request generation
  // ****************************************************************
  always_comb begin
    ctl_base = '0;
    ctl_base[pfta_pkg::CTL_PGD] = 1'b1;
    ctl_base[pfta_pkg::CTL_WRITE_ENABLE_BIT] = 1'b1;
    ctl_base[pfta_pkg::CTL_FREE] = erase_r;
    req_nxt = 1'b0;
    op_nxt = pfta_pkg::OP_TBL_RD;
    wdata_nxt = data_r;
    if (cmd_go && !long_cmd) begin
      req_nxt = 1'b1;
      case (cmd_code)
        pfta_pkg::CMD_TBL_RD: op_nxt = pfta_pkg::OP_TBL_RD;
        pfta_pkg::CMD_TBL_WT: op_nxt = pfta_pkg::OP_TBL_WT;
        pfta_pkg::CMD_SET_PTR: op_nxt = pfta_pkg::OP_SET_PTR;
        pfta_pkg::CMD_PC_STEP: op_nxt = pfta_pkg::OP_PC_STEP;
        pfta_pkg::CMD_PC_JUMP: op_nxt = pfta_pkg::OP_PC_JUMP;
        default: op_nxt = pfta_pkg::OP_PC_BRANCH;
      endcase
    end else if (state_r == HS_SEQ && step_r != pfta_pkg::STEP_GAP) begin
      req_nxt = 1'b1;
      case (step_r)
        pfta_pkg::STEP_CTRL: begin
          op_nxt = pfta_pkg::OP_WR_CTRL;
          wdata_nxt = ctl_base;
        end
        pfta_pkg::STEP_KEY1: begin
          op_nxt = pfta_pkg::OP_WR_KEY;
          wdata_nxt = pfta_pkg::KEY_FIRST;
        end
        pfta_pkg::STEP_KEY2: begin
          op_nxt = pfta_pkg::OP_WR_KEY;
          wdata_nxt = pfta_pkg::KEY_SECOND;
        end
        default: begin
          op_nxt = pfta_pkg::OP_WR_CTRL;
          wdata_nxt = ctl_base;
          wdata_nxt[pfta_pkg::CTL_WR] = 1'b1;
        end
      endcase
    end else if (state_r == HS_TAIL) begin
      req_nxt = 1'b1;
      op_nxt = pfta_pkg::OP_WR_CTRL;
      wdata_nxt = '0;
      wdata_nxt[pfta_pkg::CTL_PGD] = 1'b1;
      // Writing one keeps an aborted write visible to software
      wdata_nxt[pfta_pkg::CTL_ERR] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_r <= 1'b0;
      op_r <= pfta_pkg::OP_TBL_RD;
      wdata_r <= '0;
      addr_r <= '0;
      inc_r <= 1'b0;
    end else begin
      req_r <= req_nxt;
      op_r <= op_nxt;
      wdata_r <= wdata_nxt;
      addr_r <= preg_r;
      if (cmd_go) inc_r <= avs_writedata[pfta_pkg::CMD_INC_BIT];
    end
  end

  // ****************************************************************
  // Unlock and write sequence
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= HS_IDLE;
      step_r <= pfta_pkg::STEP_CTRL;
      erase_r <= 1'b0;
      gie_r <= 1'b1;
    end else begin
      case (state_r)
        HS_IDLE: begin
          if (cmd_go && long_cmd) begin
            state_r <= HS_SEQ;
            step_r <= pfta_pkg::STEP_CTRL;
            erase_r <= cmd_code == pfta_pkg::CMD_ERASE;
            gie_r <= 1'b0;
          end
        end
        HS_SEQ: begin
          step_r <= step_r + 3'h1;
          if (step_r == pfta_pkg::STEP_GAP) state_r <= HS_STALL;
        end
        HS_STALL: begin
          if (!bus.stall) state_r <= HS_TAIL;
        end
        HS_TAIL: begin
          state_r <= HS_IDLE;
          gie_r <= 1'b1;
        end
        default: state_r <= HS_IDLE;
      endcase
    end
  end

  assign bus.req = req_r;
  assign bus.op = op_r;
  assign bus.wdata = wdata_r;
  assign bus.addr = addr_r;
  assign bus.post_inc = inc_r;
  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;

endmodule

// ==== verif/pfta_link_assertions.sv ====
// Link checks between core end and device end
`timescale 1ns/1ps
module pfta_link_assertions #(
  parameter int WRITE_CYCLES = 20
) (
  input logic clk,
  input logic reset_n,
  input logic warm_reset,
  input logic req,
  input pfta_pkg::pfta_op_t op,
  input logic [7:0] wdata,
  input logic [21:0] addr,
  input logic post_inc,
  input logic stall,
  input logic [7:0] latch,
  input logic [21:0] ptr,
  input logic [7:0] ctrl,
  input logic [20:0] pc
);
  // ****************
  // Helper logic
  // ****************
  logic [31:0] cnt_r;
  wire go = req && !stall;
  wire tbl = op == pfta_pkg::OP_TBL_RD || op == pfta_pkg::OP_TBL_WT;
  wire [20:0] jt = {addr[19:0], 1'b0};
  wire [20:0] boff = {{9{addr[10]}}, addr[10:0], 1'b0};
  wire key1 = req && op == pfta_pkg::OP_WR_KEY && wdata == 8'h55;
  wire key2 = req && op == pfta_pkg::OP_WR_KEY && wdata == 8'haa;
  wire start_ok = req && op == pfta_pkg::OP_WR_CTRL && wdata[1] &&
    wdata[2] && wdata[7] && !wdata[6];
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      cnt_r <= 32'h0;
    else if (stall)
      cnt_r <= cnt_r + 32'h1;
    else
      cnt_r <= 32'h0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  pc_even_a: assert property (pc[0] == 1'b0)
    else $error("pc odd");
  pc_step_a: assert property (
    go && op == pfta_pkg::OP_PC_STEP |=> pc == $past(pc) + 21'h2)
    else $error("pc step wrong");
  jump_word_a: assert property (
    go && op == pfta_pkg::OP_PC_JUMP |=> pc == $past(jt))
    else $error("jump target wrong");
  branch_word_a: assert property (
    go && op == pfta_pkg::OP_PC_BRANCH |=>
    pc == $past(pc) + 21'h2 + $past(boff)) else $error("branch wrong");
  ptr_inc_a: assert property (
    go && tbl |=> ptr == $past(ptr) + {21'h0, $past(post_inc)})
    else $error("pointer update wrong");
  wt_latch_a: assert property (
    go && op == pfta_pkg::OP_TBL_WT |=> latch == $past(wdata))
    else $error("table write latch wrong");
  cfg_read_a: assert property (
    go && op == pfta_pkg::OP_TBL_RD && ptr[21] |=> latch == 8'hff)
    else $error("config read wrong");
  stall_max_a: assert property (stall |-> cnt_r < WRITE_CYCLES)
    else $error("stall too long");
  stall_len_a: assert property (
    $fell(stall) && !$past(warm_reset) |->
    $past(cnt_r) == WRITE_CYCLES - 1)
    else $error("stall length wrong");
  abort_err_a: assert property (
    warm_reset && stall |=> !stall ##1 ctrl[3])
    else $error("aborted write left no error flag");
  start_keys_a: assert property (
    $rose(stall) |-> $past(start_ok) && $past(key2, 2) && $past(key1, 3))
    else $error("write started without unlock");
  no_start_a: assert property (
    go && op == pfta_pkg::OP_WR_CTRL &&
    !(start_ok && $past(key2) && $past(key1, 2)) |=> !stall)
    else $error("unlocked write ignored rule");
  cover property ($rose(stall));
  cover property (go && op == pfta_pkg::OP_PC_BRANCH && addr[10]);
  cover property (go && op == pfta_pkg::OP_TBL_RD && ptr[21]);
endmodule

// ==== verif/program_flash_table_access_bench.sv ====
// Testbench joining both ends over the table access link
`timescale 1ns/1ps
module program_flash_table_access_bench;
  localparam logic [21:0] BASE = 22'h000140;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic warm_reset = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] fetch_word;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  logic [31:0] seed = 32'hc32e;
  logic [31:0] rd;
  logic [7:0] d[4];
  logic [7:0] m;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  pfta_if bus_if();
  pfta_flash_dev #(.WRITE_CYCLES(20)) i_pfta_flash_dev (.clk(clk),
    .reset_n(reset_n), .warm_reset(warm_reset), .bus(bus_if),
    .fetch_word(fetch_word));
  pfta_core_host i_pfta_core_host (.clk(clk), .reset_n(reset_n),
    .bus(bus_if), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  pfta_link_assertions #(.WRITE_CYCLES(20)) i_pfta_link_assertions (
    .clk(clk), .reset_n(reset_n), .warm_reset(warm_reset),
    .req(bus_if.req), .op(bus_if.op),
    .wdata(bus_if.wdata), .addr(bus_if.addr), .post_inc(bus_if.post_inc),
    .stall(bus_if.stall), .latch(bus_if.latch), .ptr(bus_if.ptr),
    .ctrl(bus_if.ctrl), .pc(bus_if.pc));
  initial forever #20 clk = ~clk;
  // ****************
  // Bus tasks
  // ****************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic fail(input string s);
    err_count++;
    $display("CHECK FAILED at %0t: %s", $time, s);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [4:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic chk(input logic [4:0] a, input logic [31:0] x);
    exp_q.push_back({1'b1, x});
    acc(1'b0, a, 32'h0);
  endtask
  task automatic cmd(input logic [2:0] c, input logic inc);
    acc(1'b1, pfta_pkg::REG_CMD, {27'h0, inc, 1'b0, c});
  endtask
  task automatic setp(input logic [21:0] p);
    acc(1'b1, pfta_pkg::REG_PTR, {10'h0, p});
    cmd(pfta_pkg::CMD_SET_PTR, 1'b0);
  endtask
  task automatic ld(input logic [21:0] p, input logic [7:0] v);
    setp(p);
    acc(1'b1, pfta_pkg::REG_DATA, {24'h0, v});
    cmd(pfta_pkg::CMD_TBL_WT, 1'b0);
  endtask
  task automatic rdb(input logic inc, input logic [7:0] x);
    cmd(pfta_pkg::CMD_TBL_RD, inc);
    chk(pfta_pkg::REG_DATA, {24'h0, x});
  endtask
  task automatic prog(input logic [2:0] c, input int cut = 0);
    int n;
    n = 0;
    cmd(c, 1'b0);
    // Optional warm reset pulse that lands inside the long write
    if (cut > 0) begin
      repeat (cut) @(posedge clk);
      warm_reset <= 1'b1;
      @(posedge clk);
      warm_reset <= 1'b0;
    end
    do begin
      exp_q.push_back(33'h0);
      acc(1'b0, pfta_pkg::REG_STATUS, 32'h0);
      n++;
    end while (rd[1:0] !== 2'b00 && n < 500);
    if (n >= 500)
      fail("write never finished");
  endtask
  // ****************
  // Checking and sequence
  // ****************
  always @(posedge clk) begin
    cyc++;
    if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e[32]) begin
        checks++;
        if (avs_readdata !== e[31:0])
          fail("read data mismatch");
      end
    end
    if (cyc == 30000) begin
      fail("timeout");
      end_of_test();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    chk(pfta_pkg::REG_STATUS, 32'h4);
    chk(pfta_pkg::REG_PC, 32'h0);
    cmd(pfta_pkg::CMD_PC_STEP, 1'b0);
    chk(pfta_pkg::REG_PC, 32'h2);
    acc(1'b1, pfta_pkg::REG_PTR, 32'h3);
    cmd(pfta_pkg::CMD_PC_JUMP, 1'b0);
    chk(pfta_pkg::REG_PC, 32'h6);
    acc(1'b1, pfta_pkg::REG_PTR, 32'h7fe);
    cmd(pfta_pkg::CMD_PC_BRANCH, 1'b0);
    chk(pfta_pkg::REG_PC, 32'h4);
    @(posedge clk);
    warm_reset <= 1'b1;
    @(posedge clk);
    warm_reset <= 1'b0;
    chk(pfta_pkg::REG_PC, 32'h0);
    setp(BASE);
    prog(pfta_pkg::CMD_ERASE);
    setp(BASE);
    for (int i = 0; i < 4; i++) begin
      d[i] = 8'(rnd());
      acc(1'b1, pfta_pkg::REG_DATA, {24'h0, d[i]});
      cmd(pfta_pkg::CMD_TBL_WT, 1'b1);
    end
    setp(BASE);
    rdb(1'b0, 8'hff);
    prog(pfta_pkg::CMD_PROGRAM);
    setp(BASE);
    for (int i = 0; i < 6; i++) rdb(1'b1, i < 4 ? d[i] : 8'hff);
    chk(pfta_pkg::REG_PTR, {10'h0, BASE + 22'd6});
    acc(1'b1, pfta_pkg::REG_PTR, 32'ha0);
    cmd(pfta_pkg::CMD_PC_JUMP, 1'b0);
    chk(pfta_pkg::REG_PC, 32'h140);
    checks++;
    if (fetch_word !== {d[1], d[0]}) fail("fetch word mismatch");
    prog(pfta_pkg::CMD_ERASE);
    m = 8'(rnd());
    ld(BASE + 22'd1, m);
    prog(pfta_pkg::CMD_PROGRAM);
    setp(BASE);
    rdb(1'b1, 8'hff);
    rdb(1'b1, m);
    ld(BASE + 22'd1, d[2]);
    prog(pfta_pkg::CMD_PROGRAM);
    setp(BASE + 22'd1);
    rdb(1'b0, m & d[2]);
    ld(BASE + 22'd2, 8'h00);
    prog(pfta_pkg::CMD_PROGRAM, 8);
    chk(pfta_pkg::REG_STATUS, 32'h8804);
    setp(BASE + 22'd2);
    rdb(1'b0, 8'hff);
    setp(22'h200000);
    rdb(1'b0, 8'hff);
    chk(5'h14, 32'h0);
    end_of_test();
  end
endmodule
